/* File: hdl/twf_pkg.sv */
// Constants and types for the two-word instruction fetch block
package twf_pkg;
    localparam int          PC_W       = 21;
    localparam int          SP_W       = 5;
    localparam logic [20:0] PC_RESET   = 21'h00_0000;
    localparam logic [20:0] VEC_HIGH   = 21'h00_0008;
    localparam logic [20:0] VEC_LOW    = 21'h00_0018;
    localparam logic [20:0] PC_STEP    = 21'h00_0002;
    localparam logic [4:0]  SP_RESET   = 5'h00;
    localparam logic [3:0]  SECOND_TAG = 4'hF;
    // First-word opcode prefixes of the two-word instructions, the relative branch and the skip test
    localparam logic [6:0]  OP_CALL    = 7'h76;   // 1110 110
    localparam logic [7:0]  OP_JUMP    = 8'hEF;   // 1110 1111
    localparam logic [3:0]  OP_MOVE    = 4'hC;    // 1100
    localparam logic [7:0]  OP_PTRLD   = 8'hEE;   // 1110 1110
    localparam logic [3:0]  OP_BRA     = 4'hD;    // 1101 0 : relative branch
    localparam logic [6:0]  OP_SKIPZ   = 7'h33;   // 0110 011 : test_skip_if_zero, top seven bits

    typedef enum logic [1:0] {
        TWF_FIRST  = 2'b00,
        TWF_SECOND = 2'b01,
        TWF_FLUSH  = 2'b10
    } twf_state_e;

    typedef enum logic [2:0] {
        TWF_K_NONE = 3'b000,
        TWF_K_CALL = 3'b001,
        TWF_K_JUMP = 3'b010,
        TWF_K_MOVE = 3'b011,
        TWF_K_PTR  = 3'b100
    } twf_kind_e;
endpackage

/* File: hdl/twf_decode.sv */
// First-word classifier for the two-word instructions
`timescale 1ns/10ps
`default_nettype none
module twf_decode
    import twf_pkg::*;
(
    // Instruction word
    input  wire logic [15:0] word,
    // Classification
    output var twf_pkg::twf_kind_e kind,
    output logic                   is_bra
);
    import twf_pkg::*;

    // Only four prefixes open a two-word instruction
    always_comb begin
        kind   = TWF_K_NONE;
        is_bra = 1'b0;
        if (word[15:9] == OP_CALL) begin
            kind = TWF_K_CALL;
        end else if (word[15:8] == OP_JUMP) begin
            kind = TWF_K_JUMP;
        end else if (word[15:8] == OP_PTRLD) begin
            kind = TWF_K_PTR;
        end else if (word[15:12] == OP_MOVE) begin
            kind = TWF_K_MOVE;
        end else if (word[15:11] == {OP_BRA, 1'b0}) begin
            is_bra = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/twf_fetch.sv */
// Program counter, fetch sequencing and two-word decode
`timescale 1ns/10ps
`default_nettype none
module twf_fetch
    import twf_pkg::*;
(
    // Clock and reset
    input  wire logic              MCLK,
    input  wire logic              SYS_RST,
    // Program memory
    input  wire logic [15:0]       INSTR_WORD,
    input  wire logic              INSTR_VALID,
    output logic [twf_pkg::PC_W-1:0] FETCH_ADDR,
    // Skip condition and interrupt wake-up
    input  wire logic              SKIP_COND,
    input  wire logic              WAKE_INT,
    input  wire logic              WAKE_HIGH,
    input  wire logic              HIGH_PRIORITY_GLOBAL_INT_ENABLE,
    input  wire logic              LOW_PRIORITY_GLOBAL_INT_ENABLE,
    // Executed instruction
    output logic                   EXEC_VALID,
    output logic [2:0]             EXEC_KIND,
    output logic [15:0]            EXEC_FIRST,
    output logic [11:0]            EXEC_LITERAL,
    output logic                   EXEC_NOP,
    // Stack
    output logic [7:0]             TOP_OF_STACK_UPPER_BYTE,
    output logic [7:0]             TOP_OF_STACK_HIGH_BYTE,
    output logic [7:0]             TOP_OF_STACK_LOW_BYTE,
    output logic [twf_pkg::SP_W-1:0] RETURN_STACK_POINTER
);
    import twf_pkg::*;

    typedef struct packed {
        twf_state_e       st;
        logic [PC_W-1:0]  pc;
        logic [15:0]      first;
        twf_kind_e        kind;
        logic             exv;
        logic [2:0]       exk;
        logic [15:0]      exf;
        logic [11:0]      lit;
        logic             nop;
        logic             skip;
        logic [23:0]      tos;
        logic [SP_W-1:0]  sp;
    } twf_state_s;

    twf_state_s q_q;
    twf_state_s d_d;
    twf_kind_e  dec_kind;
    logic       dec_bra;
    logic [PC_W-1:0] bra_off;

    twf_decode u_dec (
        .word   (INSTR_WORD),
        .kind   (dec_kind),
        .is_bra (dec_bra)
    );

    // Offset counts words, so shift into bytes
    assign bra_off = {{(PC_W-12){INSTR_WORD[10]}}, INSTR_WORD[10:0], 1'b0};

    // Next state
    always_comb begin
        d_d     = q_q;
        d_d.exv = 1'b0;
        d_d.nop = 1'b0;
        if (WAKE_INT && (HIGH_PRIORITY_GLOBAL_INT_ENABLE || LOW_PRIORITY_GLOBAL_INT_ENABLE)) begin
            d_d.tos = {3'h0, q_q.pc};
            d_d.sp  = SP_W'(q_q.sp + 1'b1);
            d_d.pc  = WAKE_HIGH ? VEC_HIGH : VEC_LOW;
            d_d.st  = TWF_FIRST;
            // A pending skip belongs to the interrupted flow, not the handler
            d_d.skip = 1'b0;
        end else if (INSTR_VALID) begin
            d_d.pc = PC_W'(q_q.pc + PC_STEP);
            unique case (q_q.st)
                TWF_FIRST: begin
                    if (q_q.skip) begin
                        // Skipped word: a two-word one also has its second word consumed as a no-op in TWF_FLUSH
                        d_d.skip = 1'b0;
                        d_d.st   = (dec_kind != TWF_K_NONE) ? TWF_FLUSH : TWF_FIRST;
                    end else if (INSTR_WORD[15:12] == SECOND_TAG) begin
                        d_d.exv = 1'b1;
                        d_d.nop = 1'b1;
                        d_d.exk = TWF_K_NONE;
                        d_d.exf = INSTR_WORD;
                    end else if (dec_kind != TWF_K_NONE) begin
                        d_d.first = INSTR_WORD;
                        d_d.kind  = dec_kind;
                        d_d.st    = TWF_SECOND;
                    end else begin
                        d_d.exv  = 1'b1;
                        d_d.exk  = TWF_K_NONE;
                        d_d.exf  = INSTR_WORD;
                        d_d.skip = (INSTR_WORD[15:9] == OP_SKIPZ) && SKIP_COND;
                        if (dec_bra) begin
                            d_d.pc = PC_W'(q_q.pc + PC_STEP + bra_off);
                        end
                    end
                end
                TWF_SECOND: begin
                    d_d.st  = TWF_FIRST;
                    d_d.exv = 1'b1;
                    d_d.exk = q_q.kind;
                    d_d.exf = q_q.first;
                    d_d.lit = INSTR_WORD[11:0];
                    if (q_q.kind == TWF_K_CALL || q_q.kind == TWF_K_JUMP) begin
                        // Word address lands in bits 20:1; bit 0 stays clear
                        d_d.pc = {INSTR_WORD[11:0], q_q.first[7:0], 1'b0};
                    end
                end
                TWF_FLUSH: begin
                    d_d.st  = TWF_FIRST;
                    d_d.exv = 1'b1;
                    d_d.nop = 1'b1;
                    d_d.exk = TWF_K_NONE;
                    d_d.exf = INSTR_WORD;
                end
                default: d_d.st = TWF_FIRST;
            endcase
        end
        d_d.pc[0] = 1'b0;
    end

    // State register
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            q_q <= '{st: TWF_FIRST, pc: PC_RESET, first: 16'h0000, kind: TWF_K_NONE,
                     exv: 1'b0, exk: 3'h0, exf: 16'h0000, lit: 12'h000, nop: 1'b0,
                     skip: 1'b0, tos: 24'h00_0000, sp: SP_RESET};
        end else begin
            q_q <= d_d;
        end
    end

    // Outputs straight from the state register
    assign FETCH_ADDR              = q_q.pc;
    assign EXEC_VALID              = q_q.exv;
    assign EXEC_KIND               = q_q.exk;
    assign EXEC_FIRST              = q_q.exf;
    assign EXEC_LITERAL            = q_q.lit;
    assign EXEC_NOP                = q_q.nop;
    assign TOP_OF_STACK_UPPER_BYTE = q_q.tos[23:16];
    assign TOP_OF_STACK_HIGH_BYTE  = q_q.tos[15:8];
    assign TOP_OF_STACK_LOW_BYTE   = q_q.tos[7:0];
    assign RETURN_STACK_POINTER    = q_q.sp;

    // Checks
    property p_pc_even;
        @(posedge MCLK) disable iff (SYS_RST) FETCH_ADDR[0] == 1'b0;
    endproperty
    a_pc_even: assert property (p_pc_even) else $error("pc odd");

    property p_step;
        @(posedge MCLK) disable iff (SYS_RST)
        (INSTR_VALID && !WAKE_INT && q_q.st == TWF_FIRST && !q_q.skip && dec_kind == TWF_K_NONE && !dec_bra)
        |=> FETCH_ADDR == $past(FETCH_ADDR) + PC_STEP;
    endproperty
    a_step: assert property (p_step) else $error("pc step wrong");

    property p_jump;
        @(posedge MCLK) disable iff (SYS_RST)
        (INSTR_VALID && !WAKE_INT && q_q.st == TWF_SECOND && q_q.kind == TWF_K_JUMP)
        |=> FETCH_ADDR == {$past(INSTR_WORD[11:0]), $past(q_q.first[7:0]), 1'b0};
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");

    property p_lone_nop;
        @(posedge MCLK) disable iff (SYS_RST)
        (INSTR_VALID && !WAKE_INT && q_q.st == TWF_FIRST && !q_q.skip && INSTR_WORD[15:12] == SECOND_TAG)
        |=> EXEC_VALID && EXEC_NOP;
    endproperty
    a_lone_nop: assert property (p_lone_nop) else $error("lone second word not nop");

    property p_literal;
        @(posedge MCLK) disable iff (SYS_RST)
        (INSTR_VALID && !WAKE_INT && q_q.st == TWF_SECOND)
        |=> EXEC_VALID && !EXEC_NOP && EXEC_LITERAL == $past(INSTR_WORD[11:0]);
    endproperty
    a_literal: assert property (p_literal) else $error("literal not taken");

    property p_vector;
        @(posedge MCLK) disable iff (SYS_RST)
        (WAKE_INT && HIGH_PRIORITY_GLOBAL_INT_ENABLE)
        |=> FETCH_ADDR == ($past(WAKE_HIGH) ? VEC_HIGH : VEC_LOW);
    endproperty
    a_vector: assert property (p_vector) else $error("vector wrong");

    property p_push;
        @(posedge MCLK) disable iff (SYS_RST)
        (WAKE_INT && (HIGH_PRIORITY_GLOBAL_INT_ENABLE || LOW_PRIORITY_GLOBAL_INT_ENABLE))
        |=> RETURN_STACK_POINTER == SP_W'($past(RETURN_STACK_POINTER) + 1'b1)
            && TOP_OF_STACK_LOW_BYTE == $past(FETCH_ADDR[7:0]);
    endproperty
    a_push: assert property (p_push) else $error("stack push wrong");

    property p_flush;
        @(posedge MCLK) disable iff (SYS_RST)
        (INSTR_VALID && !WAKE_INT && q_q.st == TWF_FIRST && q_q.skip && dec_kind != TWF_K_NONE)
        ##1 (INSTR_VALID && !WAKE_INT) |=> EXEC_NOP;
    endproperty
    a_flush: assert property (p_flush) else $error("skipped pair not nop");

    // A call lands on its word address just as a jump does
    property p_call;
        @(posedge MCLK) disable iff (SYS_RST)
        (INSTR_VALID && !WAKE_INT && q_q.st == TWF_SECOND && q_q.kind == TWF_K_CALL)
        |=> FETCH_ADDR == {$past(INSTR_WORD[11:0]), $past(q_q.first[7:0]), 1'b0};
    endproperty
    a_call: assert property (p_call) else $error("call target wrong");

    // No word and no taken wake-up: nothing may move
    property p_hold;
        @(posedge MCLK) disable iff (SYS_RST)
        (!INSTR_VALID && !(WAKE_INT && (HIGH_PRIORITY_GLOBAL_INT_ENABLE || LOW_PRIORITY_GLOBAL_INT_ENABLE)))
        |=> $stable(FETCH_ADDR) && $stable(RETURN_STACK_POINTER) && !EXEC_VALID;
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while idle");

    // Scenario coverage: pairs, wake-ups, skips, lone no-ops, calls
    c_two_word: cover property (@(posedge MCLK) disable iff (SYS_RST) EXEC_VALID && EXEC_KIND == 3'h3);
    c_irq:      cover property (@(posedge MCLK) disable iff (SYS_RST) WAKE_INT && LOW_PRIORITY_GLOBAL_INT_ENABLE);
    c_flush:    cover property (@(posedge MCLK) disable iff (SYS_RST) q_q.st == TWF_FLUSH);
    c_lone_nop: cover property (@(posedge MCLK) disable iff (SYS_RST) EXEC_VALID && EXEC_NOP);
    c_call:     cover property (@(posedge MCLK) disable iff (SYS_RST) EXEC_VALID && EXEC_KIND == 3'h1);
endmodule
`default_nettype wire

/* File: test/twf_pmem.sv */
// Program memory model feeding instruction words to the fetch block
`timescale 1ns/10ps
`default_nettype none
module twf_pmem (
    // Fetch side
    input  wire logic [20:0] addr,
    input  wire logic        en,
    output logic [15:0]      word,
    output logic             valid
);
    logic [15:0] mem [64];
    // Stalled bus shows the inverted word so stale data never passes
    assign valid = en;
    assign word  = en ? mem[addr[6:1]] : ~mem[addr[6:1]];
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the two-word instruction fetch block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import twf_pkg::*;
    localparam logic [15:0] PROG [16] = '{16'h0E55, 16'hEF03, 16'hF000, 16'hC123, 16'hF456, 16'hEE10,
        16'hF0AB, 16'hEC0A, 16'hF000, 16'h0E00, 16'hF123, 16'h6600, 16'hC789, 16'hF456, 16'hD001, 16'h0E77};
    logic        mclk = 1'b0, sys_rst = 1'b1, en = 1'b0, skip = 1'b1, wake = 1'b0, whigh = 1'b0;
    logic        gh = 1'b0, gl = 1'b0;
    logic        valid, xv, xnop;
    logic [15:0] word, xf;
    logic [20:0] fa;
    logic [2:0]  xk;
    logic [11:0] xl;
    logic [7:0]  tu, th, tl;
    logic [4:0]  sp;
    int          num_errors = 0, n_compared = 0;
    // Clock, 20 ns period
    always #10 mclk = ~mclk;
    twf_pmem pm (.addr(fa), .en(en), .word(word), .valid(valid));
    twf_fetch dut (.MCLK(mclk), .SYS_RST(sys_rst), .INSTR_WORD(word), .INSTR_VALID(valid), .FETCH_ADDR(fa),
        .SKIP_COND(skip), .WAKE_INT(wake), .WAKE_HIGH(whigh), .HIGH_PRIORITY_GLOBAL_INT_ENABLE(gh),
        .LOW_PRIORITY_GLOBAL_INT_ENABLE(gl), .EXEC_VALID(xv), .EXEC_KIND(xk), .EXEC_FIRST(xf),
        .EXEC_LITERAL(xl), .EXEC_NOP(xnop), .TOP_OF_STACK_UPPER_BYTE(tu), .TOP_OF_STACK_HIGH_BYTE(th),
        .TOP_OF_STACK_LOW_BYTE(tl), .RETURN_STACK_POINTER(sp));
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic end_sim;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Inputs move 1 ns after the edge, outputs are read there too
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    // Wait for one instruction's pulse; pulses before it must be of kind none
    task automatic run_to(input logic [15:0] f, input logic [2:0] k, input logic [11:0] l,
                          input logic n, input logic [20:0] a);
        int i;
        for (i = 0; i < 20; i++) begin
            tick();
            chk(fa[0] === 1'b0, "odd fetch address");
            if (xv === 1'b1 && xf === f) break;
            if (xv === 1'b1) chk(xk === 3'h0, "skipped first word executed");
        end
        if (i == 20) begin
            chk(1'b0, "no execute pulse");
            end_sim();
        end
        chk(xk === k && xnop === n, "kind or no-op flag");
        if (k != 3'h0) chk(xl === l, "literal");
        chk(fa === a, "next fetch address");
    endtask
    task automatic t_reset;
        repeat (10) tick();
        sys_rst = 1'b0;
        tick();
        chk(fa === PC_RESET && xv === 1'b0 && xnop === 1'b0, "reset state");
        chk(sp === SP_RESET && {tu, th, tl} === 24'h00_0000, "reset stack");
        en = 1'b1;
    endtask
    // Whole program: jump, move, pointer load, call, lone no-op, skip, branch
    task automatic t_flow;
        run_to(16'h0E55, 3'h0, 12'h000, 1'b0, 21'h00_0002);
        run_to(16'hEF03, 3'h2, 12'h000, 1'b0, 21'h00_0006);
        run_to(16'hC123, 3'h3, 12'h456, 1'b0, 21'h00_000A);
        run_to(16'hEE10, 3'h4, 12'h0AB, 1'b0, 21'h00_000E);
        run_to(16'hEC0A, 3'h1, 12'h000, 1'b0, 21'h00_0014);
        run_to(16'hF123, 3'h0, 12'h000, 1'b1, 21'h00_0016);
        run_to(16'hF456, 3'h0, 12'h000, 1'b1, 21'h00_001C);
        run_to(16'hD001, 3'h0, 12'h000, 1'b0, 21'h00_0020);
        run_to(16'h0E00, 3'h0, 12'h000, 1'b0, 21'h00_0022);
    endtask
    // Memory stalled; wake refused, then both priorities pushing the counter
    task automatic t_wake;
        logic [20:0] pc;
        logic [4:0]  s;
        en = 1'b0;
        pc = fa;
        s = sp;
        wake = 1'b1;
        tick();
        wake = 1'b0;
        tick();
        chk(fa === pc && sp === s, "wake without enable acted");
        {gh, whigh, wake} = 3'b111;
        tick();
        wake = 1'b0;
        tick();
        chk(fa === VEC_HIGH, "high vector");
        chk({tu, th, tl} === {3'b000, pc} && sp === s + 5'h01, "high push");
        {gh, gl, whigh, wake} = 4'b0101;
        tick();
        wake = 1'b0;
        tick();
        chk(fa === VEC_LOW, "low vector");
        chk({tu, th, tl} === {3'b000, VEC_HIGH} && sp === s + 5'h02, "low push");
        en = 1'b1;
        run_to(16'hC789, 3'h3, 12'h456, 1'b0, 21'h00_001C);
    endtask
    // Reset in mid-run clears the pushed stack; then a failing skip test runs the pair in full
    task automatic t_noskip;
        en = 1'b0;
        sys_rst = 1'b1;
        skip = 1'b0;
        pm.mem[0] = 16'hEF0B;
        pm.mem[1] = 16'hF000;
        t_reset();
        run_to(16'hEF0B, 3'h2, 12'h000, 1'b0, 21'h00_0016);
        run_to(16'h6600, 3'h0, 12'h000, 1'b0, 21'h00_0018);
        run_to(16'hC789, 3'h3, 12'h456, 1'b0, 21'h00_001C);
    endtask
    initial begin
        for (int i = 0; i < 64; i++) pm.mem[i] = (i < 16) ? PROG[i] : 16'h0E00;
        t_reset();
        t_flow();
        t_wake();
        t_noskip();
        end_sim();
    end
endmodule
`default_nettype wire
